/* design/csh_cfg.svh */
`ifndef CSH_CFG_SVH
`define CSH_CFG_SVH
// Power-on reset interval in microseconds and its cycle count at 250 MHz
`define CSH_POR_TIME_US 100
`define CSH_CLK_MHZ 250
`define CSH_POR_CYCLES (`CSH_POR_TIME_US * `CSH_CLK_MHZ)
`define CSH_CNT_W 24
// Initialization cycle length in clocks
`define CSH_INIT_CYCLES 24'h000010
`endif

/* design/csh_pkg.sv */
package csh_pkg;
    typedef enum logic [2:0] {
        CSH_POR = 3'b000,
        CSH_IDLE = 3'b001,
        CSH_LOAD = 3'b010,
        CSH_WAIT_DONE = 3'b011,
        CSH_INIT = 3'b100,
        CSH_USER = 3'b101,
        CSH_ERROR = 3'b110,
        CSH_CLEARED = 3'b111
    } csh_state_t;
endpackage

/* design/csh_status_handshake.sv */
// How it works
// - Status held low until power-on interval ends
// - Configuration error pulls status line low
// - External low status during load means error
// - User mode ignores status line transitions
// - Complete line low until configuration finished
// - Release complete line when the data load is done, before initialization begins
// - Complete line high starts init, user mode
// - Configured device ignores low complete line
// - Rising released status starts configuration attempt
// - Request low in user mode resets device
`timescale 1ns/100ps
`include "csh_cfg.svh"
module csh_status_handshake #(
    parameter logic [23:0] POR_CYCLES = 24'(`CSH_POR_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration request pin, active low
    input wire logic cfgRequest_n,
    // Status line, open drain
    input wire logic statusLineIn,
    output logic statusLineOut,
    output logic statusLineOe,
    // Load complete line, open drain
    input wire logic loadCompleteLineIn,
    output logic loadCompleteLineOut,
    output logic loadCompleteLineOe,
    // Data loader events
    input wire logic loadDone,
    input wire logic loadError,
    // Device state
    output logic userMode,
    output logic errorFlag
);
    csh_pkg::csh_state_t state_reg;
    csh_pkg::csh_state_t state_next;
    logic [23:0] count_reg;
    logic [23:0] count_next;
    logic reqMeta_reg, reqSync_reg;
    logic statMeta_reg, statSync_reg, statPrev_reg;
    logic doneMeta_reg, doneSync_reg;

    // Pins come from outside the clock domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqMeta_reg <= 1'b0;
            reqSync_reg <= 1'b0;
            statMeta_reg <= 1'b0;
            statSync_reg <= 1'b0;
            statPrev_reg <= 1'b0;
            doneMeta_reg <= 1'b0;
            doneSync_reg <= 1'b0;
        end else begin
            reqMeta_reg <= cfgRequest_n;
            reqSync_reg <= reqMeta_reg;
            statMeta_reg <= statusLineIn;
            statSync_reg <= statMeta_reg;
            statPrev_reg <= statSync_reg;
            doneMeta_reg <= loadCompleteLineIn;
            doneSync_reg <= doneMeta_reg;
        end
    end

    wire statRise = statSync_reg & ~statPrev_reg;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            csh_pkg::CSH_POR: begin
                if (count_reg >= POR_CYCLES - 24'h000001) begin
                    state_next = csh_pkg::CSH_IDLE;
                    count_next = 24'h000000;
                end else begin
                    count_next = count_reg + 24'h000001;
                end
            end
            csh_pkg::CSH_IDLE: begin
                // Released status rising with request high starts loading
                if (!reqSync_reg) begin
                    state_next = csh_pkg::CSH_CLEARED;
                end else if (statRise) begin
                    state_next = csh_pkg::CSH_LOAD;
                end
            end
            csh_pkg::CSH_LOAD: begin
                if (!reqSync_reg) begin
                    state_next = csh_pkg::CSH_CLEARED;
                end else if (loadError || !statSync_reg) begin
                    state_next = csh_pkg::CSH_ERROR;
                end else if (loadDone) begin
                    state_next = csh_pkg::CSH_WAIT_DONE;
                end
            end
            csh_pkg::CSH_WAIT_DONE: begin
                if (!reqSync_reg) begin
                    state_next = csh_pkg::CSH_CLEARED;
                end else if (!statSync_reg) begin
                    state_next = csh_pkg::CSH_ERROR;
                end else if (doneSync_reg) begin
                    state_next = csh_pkg::CSH_INIT;
                    count_next = 24'h000000;
                end
            end
            csh_pkg::CSH_INIT: begin
                if (!reqSync_reg) begin
                    state_next = csh_pkg::CSH_CLEARED;
                end else if (!statSync_reg) begin
                    state_next = csh_pkg::CSH_ERROR;
                end else if (count_reg >= `CSH_INIT_CYCLES - 24'h000001) begin
                    state_next = csh_pkg::CSH_USER;
                end else begin
                    count_next = count_reg + 24'h000001;
                end
            end
            csh_pkg::CSH_USER: begin
                // Status and complete lines are not looked at here
                if (!reqSync_reg) begin
                    state_next = csh_pkg::CSH_CLEARED;
                end
            end
            csh_pkg::CSH_ERROR: begin
                // Only a request pulse recovers; status stays low
                if (!reqSync_reg) begin
                    state_next = csh_pkg::CSH_CLEARED;
                end
            end
            csh_pkg::CSH_CLEARED: begin
                // Going through IDLE lets the status line settle high first;
                // loading straight away would read the stale low level as an error
                if (reqSync_reg) begin
                    state_next = csh_pkg::CSH_IDLE;
                end
            end
            default: begin
                state_next = csh_pkg::CSH_POR;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= csh_pkg::CSH_POR;
            count_reg <= 24'h000000;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Output value is always low; only the enable moves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusLineOut <= 1'b0;
            statusLineOe <= 1'b1;
            loadCompleteLineOut <= 1'b0;
            loadCompleteLineOe <= 1'b1;
            userMode <= 1'b0;
            errorFlag <= 1'b0;
        end else begin
            statusLineOut <= 1'b0;
            loadCompleteLineOut <= 1'b0;
            statusLineOe <= (state_next == csh_pkg::CSH_POR) || (state_next == csh_pkg::CSH_ERROR)
                || (state_next == csh_pkg::CSH_CLEARED);
            loadCompleteLineOe <= (state_next != csh_pkg::CSH_WAIT_DONE) && (state_next != csh_pkg::CSH_INIT)
                && (state_next != csh_pkg::CSH_USER);
            userMode <= (state_next == csh_pkg::CSH_USER);
            errorFlag <= (state_next == csh_pkg::CSH_ERROR);
        end
    end

    status_por_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_POR) |-> statusLineOe)
        else $error("status released during power-on interval");
    idle_release_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_IDLE) |-> !statusLineOe)
        else $error("status still pulled after power-on interval");
    error_pull_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_LOAD && reqSync_reg && loadError) |=> statusLineOe && errorFlag)
        else $error("load error did not pull status low");
    ext_error_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_INIT && reqSync_reg && !statSync_reg) |=> errorFlag)
        else $error("external status low not taken as error");
    wait_error_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_WAIT_DONE && reqSync_reg && !statSync_reg) |=> errorFlag)
        else $error("external status low missed while waiting");
    user_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_USER && reqSync_reg) |=> userMode)
        else $error("user mode left without request");
    done_low_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_LOAD) |-> loadCompleteLineOe)
        else $error("complete line released during load");
    done_release_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_LOAD && reqSync_reg && statSync_reg && !loadError && loadDone)
        |=> !loadCompleteLineOe)
        else $error("complete line not released after load");
    init_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state_reg == csh_pkg::CSH_INIT) |-> ##[1:16] (state_reg != csh_pkg::CSH_INIT))
        else $error("initialization overran its length");
    init_user_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_INIT && reqSync_reg && statSync_reg
        && count_reg == `CSH_INIT_CYCLES - 24'h000001) |=> userMode)
        else $error("initialization end did not enter user mode");
    start_load_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_IDLE && reqSync_reg && statRise) |=> state_reg == csh_pkg::CSH_LOAD)
        else $error("status rise did not start loading");
    request_reset_a: assert property (@(posedge clk) disable iff (rst)
        (userMode && !reqSync_reg) |=> !userMode ##0 statusLineOe)
        else $error("request low did not clear user mode");
    clear_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == csh_pkg::CSH_CLEARED) |-> statusLineOe && loadCompleteLineOe)
        else $error("lines not held low while cleared");

    // Open-drain pins may never drive a high level
    line_low_a: assert property (@(posedge clk) disable iff (rst)
        !statusLineOut && !loadCompleteLineOut)
        else $error("shared line driven high");
endmodule

/* tb/csh_host_model.sv */
`timescale 1ns/100ps
module csh_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device pull-down enables and driven values
    input wire logic devStatusOe,
    input wire logic devCompleteOe,
    input wire logic devStatusOut,
    input wire logic devCompleteOut,
    // Bench commands
    input wire logic pullStatus,
    input wire logic pullComplete,
    // Resolved wires and retry count
    output logic statusWire,
    output logic completeWire,
    output logic [7:0] retryCount
);
    logic statusSeen;
    // Pull-ups: a released line reads high
    assign statusWire = (devStatusOe ? devStatusOut : 1'b1) & ~pullStatus;
    assign completeWire = (devCompleteOe ? devCompleteOut : 1'b1) & ~pullComplete;
    // Status fall starts a retry; configured part only reloads via request pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusSeen <= 1'b0;
            retryCount <= 8'h00;
        end else begin
            statusSeen <= statusWire;
            if (statusSeen && !statusWire) retryCount <= retryCount + 8'h01;
        end
    end
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam int POR = 20;
    logic clk = 1'b0, rst = 1'b1, cfgReq_n = 1'b1, loadDone = 1'b0, loadError = 1'b0;
    logic pullS = 1'b0, pullC = 1'b0, sWire, cWire, sOe, cOe, sOut, cOut, userMode, errorFlag;
    logic [7:0] retryCount, retryBefore;
    logic [31:0] lfsr = 32'hc17e;
    int err_count = 0, n_compared = 0;
    always #2 clk = ~clk;
    csh_status_handshake #(.POR_CYCLES(24'(POR))) dut (.clk(clk), .rst(rst), .cfgRequest_n(cfgReq_n),
        .statusLineIn(sWire), .statusLineOut(sOut), .statusLineOe(sOe), .loadCompleteLineIn(cWire),
        .loadCompleteLineOut(cOut), .loadCompleteLineOe(cOe), .loadDone(loadDone), .loadError(loadError),
        .userMode(userMode), .errorFlag(errorFlag));
    csh_host_model host (.clk(clk), .rst(rst), .devStatusOe(sOe), .devCompleteOe(cOe),
        .devStatusOut(sOut), .devCompleteOut(cOut), .pullStatus(pullS),
        .pullComplete(pullC), .statusWire(sWire), .completeWire(cWire), .retryCount(retryCount));
    function automatic logic [31:0] lfsrNext(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic pick(input int s);
        case (s)
            0: return userMode;
            1: return cOe;
            default: return sOe;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #0.5;
    endtask
    task automatic chk(input logic act, input logic exp, input string what);
        n_compared++;
        if (act !== exp) begin
            err_count++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic waitSig(input int s, input logic val, input int lim);
        for (int i = 0; i < lim && pick(s) !== val; i++) tick(1);
        chk(pick(s), val, "wait ran out");
    endtask
    task automatic doLoad();
        lfsr = lfsrNext(lfsr);
        tick(4 + int'(lfsr[2:0]));
        chk(cOe, 1'b1, "complete released early");
        loadDone = 1'b1;
        waitSig(1, 1'b0, 8);
        loadDone = 1'b0;
        chk(userMode, 1'b0, "user mode before init");
        waitSig(0, 1'b1, 30);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        $display("ERROR %0t watchdog", $time);
        test_done();
    end
    initial begin
        tick(20);
        rst = 1'b0;
        tick(POR - 4);
        chk(sOe, 1'b1, "status freed during power-on");
        waitSig(2, 1'b0, 12);
        doLoad();
        $display("test power-up load ended");
        pullS = 1'b1;
        pullC = 1'b1;
        tick(10);
        chk(userMode, 1'b1, "user mode lost on low lines");
        chk(errorFlag, 1'b0, "error in user mode");
        pullS = 1'b0;
        pullC = 1'b0;
        tick(6);
        chk(userMode, 1'b1, "user mode lost on release");
        cfgReq_n = 1'b0;
        tick(6);
        chk(userMode, 1'b0, "request low ignored");
        chk(cOe, 1'b1, "complete not held low");
        cfgReq_n = 1'b1;
        tick(6);
        doLoad();
        $display("test user mode and request ended");
        // Random error kind and moment; each reload is entered via the request pin
        for (int k = 0; k < 6; k++) begin
            cfgReq_n = 1'b0;
            tick(5);
            cfgReq_n = 1'b1;
            lfsr = lfsrNext(lfsr);
            tick(6 + int'(lfsr[2:1]));
            retryBefore = retryCount;
            if (lfsr[0]) loadError = 1'b1;
            else pullS = 1'b1;
            tick(1);
            loadError = 1'b0;
            tick(5);
            pullS = 1'b0;
            chk(errorFlag, 1'b1, "error state missed");
            chk(sOe, 1'b1, "status not pulled on error");
            chk(userMode, 1'b0, "user mode after error");
            chk(retryCount != retryBefore, 1'b1, "no retry seen");
            chk(sOut | cOut, 1'b0, "line driven high");
        end
        $display("test error handling ended");
        // Far side pulls status low during initialization
        cfgReq_n = 1'b0;
        tick(5);
        cfgReq_n = 1'b1;
        tick(8);
        loadDone = 1'b1;
        waitSig(1, 1'b0, 8);
        loadDone = 1'b0;
        tick(6);
        chk(userMode, 1'b0, "initialization skipped");
        pullS = 1'b1;
        tick(5);
        pullS = 1'b0;
        chk(errorFlag, 1'b1, "status low in init missed");
        chk(userMode, 1'b0, "user mode after init error");
        $display("test init error ended");
        test_done();
    end
endmodule
